// ### usp_map.svh
// Purpose: Address map, field positions and timing counts of the serial port
// Assumes: Included by bare name, after the package in compile order
// Notes:   Definitions only
`ifndef USP_MAP_SVH
`define USP_MAP_SVH

// Special function register addresses
`define USP_CTL_ADDR     8'h98
`define USP_BUF_ADDR     8'h99
`define USP_CTL_RESET    8'h00
`define USP_FERR_RESET   1'b0

// Control/status field positions
`define USP_BIT_SM_HIGH  7
`define USP_BIT_SM_LOW   6
`define USP_BIT_MP_EN    5
`define USP_BIT_RX_EN    4
`define USP_BIT_TX_NINTH 3
`define USP_BIT_RX_NINTH 2
`define USP_BIT_TX_DONE  1
`define USP_BIT_RX_DONE  0

// Mode 0: six clocks per bit, shift clock low for phases 0..2
`define USP_M0_LAST      4'd5
`define USP_M0_HIGH      4'd3
`define USP_M0_SAMPLE    4'd3
`define USP_M0_BITS      4'd8

// Async modes: sixteen sample ticks per bit
`define USP_OS_LAST      4'd15
`define USP_OS_MID       4'd7
`define USP_M1_BITS      4'd10
`define USP_M23_BITS     4'd11
`define USP_M1_DATA      4'd8
`define USP_M23_DATA     4'd9

// Mode 2 sample tick divider: 1 gives clock/16, 2 gives clock/32
`define USP_DIV_FAST     2'd1
`define USP_DIV_SLOW     2'd2

`endif

// ### usp_pkg.sv
// Purpose: Types shared by the serial port files
// Assumes: Nothing
// Notes:   Numeric constants live in usp_map.svh
package usp_pkg;

  typedef enum logic [1:0] {
    USP_MODE_SHIFT,
    USP_MODE_UART8,
    USP_MODE_UART9_FIXED,
    USP_MODE_UART9_VAR
  } usp_mode_t;

  typedef enum logic {
    USP_TX_IDLE,
    USP_TX_SHIFT
  } usp_tx_state_t;

  typedef enum logic [1:0] {
    USP_RX_IDLE,
    USP_RX_START,
    USP_RX_DATA
  } usp_rx_state_t;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_filter_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } usp_ctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
  } usp_sfr_req_t;

endpackage : usp_pkg

// ### usp_tick_div.sv
// Purpose: Divides the clock into a one-cycle tick every div_in enabled cycles
// Assumes: div_in is at least 1
// Notes:   Tick is registered, so it lags the count by one cycle
`timescale 1ns/1ps
module usp_tick_div #(
  parameter int CW = 2
) (
  input  wire logic          ref_clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          ce_in,
  input  wire logic          en_in,
  input  wire logic [CW-1:0] div_in,
  output logic               tick_out
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_r;
  logic          tick_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!en_in) begin
      cnt_nxt = '0;
    end else if (cnt_r >= div_in - 1'b1) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce_in) begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;
endmodule : usp_tick_div

// ### usp_serial_port.sv
// Purpose: Full-duplex serial port, shift-register mode and three async modes
// Assumes: CPU special function register strobes synchronous to ref_clk_in
// Notes:   Pin outputs are registered and lag internal state by one cycle
// Function
// - Modes 1 and 3 time bits from timer 1 overflow; modes 0, 2 fixed.
// - Transmit and receive run independently and at the same time in modes 1 to 3.
// - Receiver runs ahead of reads; a new byte overwrites an unread one.
// - Buffer write loads transmitter; buffer read returns separate receive register.
// - Mode 0: data on receive line, clock on transmit line, 8 bits, clock/6.
// - Mode 1: start low, 8 data LSB first, stop high; 10 bits.
// - Mode 1 reception stores the stop bit as the receive ninth bit.
// - Modes 2, 3: start, 8 data, ninth from transmit ninth bit, stop.
// - Modes 2, 3 store received ninth bit; stop bit not stored.
// - Mode 2 rate is clock/16 or clock/32 by fixed-rate select.
// - Mode 3 equals mode 2 except its rate follows timer 1.
// - Any write to the buffer address starts a transmission.
// - Mode 0 reception starts when receive done is 0 and enable is 1.
// - Async reception starts on a start bit while receive enable is 1.
// - Control bit 7 shows high mode bit or framing error per select.
// - Framing error set when a received frame has no valid stop bit.
// - Framing error stays set until software clears it.
// - Control/status register at 98h, reset 00h, bit addressable.
// - Filter on: modes 2, 3 need ninth 1; mode 1 needs valid stop.
`timescale 1ns/1ps
`include "usp_map.svh"
module usp_serial_port (
  input  wire logic                  ref_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  ce_in,
  input  wire usp_pkg::usp_sfr_req_t sfr_req_in,
  output logic [7:0]                 sfr_rdata_out,
  input  wire logic                  bit7_view_select_in,
  input  wire logic                  fixed_rate_select_in,
  input  wire logic                  t1_overflow_in,
  input  wire logic                  rxd_in,
  output logic                       rxd_out,
  output logic                       rxd_oe_n_out,
  output logic                       txd_out,
  output logic                       tx_done_flag_out,
  output logic                       rx_done_flag_out,
  output logic                       frame_error_flag_out
);
  import usp_pkg::*;

  usp_ctl_t      ctl_r;
  usp_ctl_t      ctl_nxt;
  logic          ferr_r;
  logic          ferr_nxt;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;
  usp_mode_t     mode;
  logic          is_m0;
  logic          div_tick;
  logic          os_tick;
  logic          step;
  logic          wr_ctl;
  logic          bit_ctl;
  logic          wr_buf;
  logic [7:0]    ctl_view;
  logic [7:0]    wmask;
  logic [7:0]    wval;
  logic [7:0]    merged;
  // Transmit group
  usp_tx_state_t tx_state_r;
  usp_tx_state_t tx_state_nxt;
  logic [10:0]   tx_shift_r;
  logic [10:0]   tx_shift_nxt;
  logic [3:0]    tx_left_r;
  logic [3:0]    tx_left_nxt;
  logic [3:0]    tx_ph_r;
  logic [3:0]    tx_ph_nxt;
  logic [3:0]    tx_last;
  logic          tx_done_evt;
  // Receive group
  usp_rx_state_t rx_state_r;
  usp_rx_state_t rx_state_nxt;
  logic [3:0]    rx_ph_r;
  logic [3:0]    rx_ph_nxt;
  logic [3:0]    rx_cnt_r;
  logic [3:0]    rx_cnt_nxt;
  logic [8:0]    rx_sh_r;
  logic [8:0]    rx_sh_nxt;
  logic [7:0]    rx_buf_r;
  logic [7:0]    rx_buf_nxt;
  logic          rxd_prev_r;
  logic          rx_load_evt;
  logic          rx_ninth;
  logic          ferr_evt;
  logic [3:0]    rx_ndata;
  // Pin group
  logic          txd_r;
  logic          txd_nxt;
  logic          rxd_o_r;
  logic          rxd_o_nxt;
  logic          rxd_oe_n_r;
  logic          rxd_oe_n_nxt;

  assign mode  = usp_mode_t'({ctl_r.mode_select_high, ctl_r.mode_select_low});
  assign is_m0 = (mode == USP_MODE_SHIFT);

  usp_tick_div #(
    .CW(2)
  ) u_mode2_div (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .en_in      (mode == USP_MODE_UART9_FIXED),
    .div_in     (fixed_rate_select_in ? `USP_DIV_FAST : `USP_DIV_SLOW),
    .tick_out   (div_tick)
  );

  // Sample tick: 16 per bit in async modes; mode 0 steps on every clock
  always_comb begin
    unique case (mode)
      USP_MODE_UART9_FIXED: os_tick = div_tick;
      USP_MODE_UART8:       os_tick = t1_overflow_in;
      USP_MODE_UART9_VAR:   os_tick = t1_overflow_in;
      USP_MODE_SHIFT:       os_tick = 1'b0;
    endcase
  end
  assign step = is_m0 ? 1'b1 : os_tick;

  // Bus decode
  assign wr_ctl   = sfr_req_in.wr && (sfr_req_in.addr == `USP_CTL_ADDR);
  assign bit_ctl  = sfr_req_in.bit_wr && (sfr_req_in.addr == `USP_CTL_ADDR);
  assign wr_buf   = sfr_req_in.wr && (sfr_req_in.addr == `USP_BUF_ADDR);
  assign ctl_view = {bit7_view_select_in ? ferr_r : ctl_r.mode_select_high,
                     ctl_r[6:0]};

  // Control/status register
  always_comb begin
    wmask = 8'h00;
    wval  = 8'h00;
    if (wr_ctl) begin
      wmask = 8'hff;
      wval  = sfr_req_in.wdata;
    end else if (bit_ctl) begin
      wmask = 8'h01 << sfr_req_in.bit_sel;
      wval  = {8{sfr_req_in.bit_val}};
    end
    merged   = (ctl_view & ~wmask) | (wval & wmask);
    ctl_nxt  = usp_ctl_t'({ctl_r.mode_select_high, merged[6:0]});
    ferr_nxt = ferr_r;
    if (bit7_view_select_in) begin
      ferr_nxt = merged[`USP_BIT_SM_HIGH];
    end else begin
      ctl_nxt.mode_select_high = merged[`USP_BIT_SM_HIGH];
    end
    // Hardware sets win over a same-cycle software clear
    if (tx_done_evt) begin
      ctl_nxt.tx_done_flag = 1'b1;
    end
    if (rx_load_evt) begin
      ctl_nxt.rx_done_flag = 1'b1;
      ctl_nxt.rx_ninth_bit = rx_ninth;
    end
    if (ferr_evt) begin
      ferr_nxt = 1'b1;
    end
    rdata_nxt = 8'h00;
    if (sfr_req_in.rd && (sfr_req_in.addr == `USP_CTL_ADDR)) begin
      rdata_nxt = ctl_view;
    end else if (sfr_req_in.rd && (sfr_req_in.addr == `USP_BUF_ADDR)) begin
      rdata_nxt = rx_buf_r;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctl_r   <= usp_ctl_t'(`USP_CTL_RESET);
      ferr_r  <= `USP_FERR_RESET;
      rdata_r <= 8'h00;
    end else if (ce_in) begin
      ctl_r   <= ctl_nxt;
      ferr_r  <= ferr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Transmitter, fully separate from the receiver
  assign tx_last = is_m0 ? `USP_M0_LAST : `USP_OS_LAST;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_shift_nxt = tx_shift_r;
    tx_left_nxt  = tx_left_r;
    tx_ph_nxt    = tx_ph_r;
    tx_done_evt  = 1'b0;
    if (wr_buf) begin
      // A write mid-frame restarts; the old frame is abandoned
      tx_state_nxt = USP_TX_SHIFT;
      tx_ph_nxt    = 4'd0;
      unique case (mode)
        USP_MODE_SHIFT: begin
          tx_shift_nxt = {3'b111, sfr_req_in.wdata};
          tx_left_nxt  = `USP_M0_BITS;
        end
        USP_MODE_UART8: begin
          tx_shift_nxt = {2'b11, sfr_req_in.wdata, 1'b0};
          tx_left_nxt  = `USP_M1_BITS;
        end
        USP_MODE_UART9_FIXED, USP_MODE_UART9_VAR: begin
          tx_shift_nxt = {1'b1, ctl_r.tx_ninth_bit, sfr_req_in.wdata, 1'b0};
          tx_left_nxt  = `USP_M23_BITS;
        end
      endcase
    end else if ((tx_state_r == USP_TX_SHIFT) && step) begin
      if (tx_ph_r == tx_last) begin
        tx_ph_nxt    = 4'd0;
        tx_shift_nxt = {1'b1, tx_shift_r[10:1]};
        tx_left_nxt  = tx_left_r - 4'd1;
        if (tx_left_r == 4'd1) begin
          tx_state_nxt = USP_TX_IDLE;
          tx_done_evt  = 1'b1;
        end
      end else begin
        tx_ph_nxt = tx_ph_r + 4'd1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tx_state_r <= USP_TX_IDLE;
      tx_shift_r <= 11'h7ff;
      tx_left_r  <= 4'd0;
      tx_ph_r    <= 4'd0;
    end else if (ce_in) begin
      tx_state_r <= tx_state_nxt;
      tx_shift_r <= tx_shift_nxt;
      tx_left_r  <= tx_left_nxt;
      tx_ph_r    <= tx_ph_nxt;
    end
  end

  // Receiver
  assign rx_ndata = (mode == USP_MODE_UART8) ? `USP_M1_DATA : `USP_M23_DATA;

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_ph_nxt    = rx_ph_r;
    rx_cnt_nxt   = rx_cnt_r;
    rx_sh_nxt    = rx_sh_r;
    rx_buf_nxt   = rx_buf_r;
    rx_load_evt  = 1'b0;
    rx_ninth     = ctl_r.rx_ninth_bit;
    ferr_evt     = 1'b0;
    unique case (rx_state_r)
      USP_RX_IDLE: begin
        rx_ph_nxt  = 4'd0;
        rx_cnt_nxt = 4'd0;
        if (is_m0) begin
          // Mode 0 shares both pins with the transmitter, so it waits for it
          if (!ctl_r.rx_done_flag && ctl_r.rx_enable &&
              (tx_state_r == USP_TX_IDLE) && !wr_buf) begin
            rx_state_nxt = USP_RX_DATA;
          end
        end else if (ctl_r.rx_enable && rxd_prev_r && !rxd_in) begin
          rx_state_nxt = USP_RX_START;
        end
      end
      USP_RX_START: begin
        if (step) begin
          if (rx_ph_r == `USP_OS_MID) begin
            rx_ph_nxt    = 4'd0;
            // A glitch gone by mid-bit is not a start bit
            rx_state_nxt = rxd_in ? USP_RX_IDLE : USP_RX_DATA;
          end else begin
            rx_ph_nxt = rx_ph_r + 4'd1;
          end
        end
      end
      USP_RX_DATA: begin
        if (is_m0) begin
          rx_ph_nxt = (rx_ph_r == `USP_M0_LAST) ? 4'd0 : rx_ph_r + 4'd1;
          if (rx_ph_r == `USP_M0_SAMPLE) begin
            rx_sh_nxt  = {rxd_in, rx_sh_r[8:1]};
            rx_cnt_nxt = rx_cnt_r + 4'd1;
          end
          if ((rx_ph_r == `USP_M0_LAST) && (rx_cnt_r == `USP_M0_BITS)) begin
            rx_buf_nxt   = rx_sh_r[8:1];
            rx_load_evt  = 1'b1;
            rx_state_nxt = USP_RX_IDLE;
          end
        end else if (step) begin
          if (rx_ph_r == `USP_OS_LAST) begin
            rx_ph_nxt = 4'd0;
            if (rx_cnt_r < rx_ndata) begin
              rx_sh_nxt  = {rxd_in, rx_sh_r[8:1]};
              rx_cnt_nxt = rx_cnt_r + 4'd1;
            end else begin
              // Stop bit sampled mid-bit; the next start edge can follow
              rx_state_nxt = USP_RX_IDLE;
              ferr_evt     = !rxd_in;
              if (mode == USP_MODE_UART8) begin
                if (!ctl_r.multiproc_filter_enable || rxd_in) begin
                  rx_buf_nxt  = rx_sh_r[8:1];
                  rx_ninth    = rxd_in;
                  rx_load_evt = 1'b1;
                end
              end else if (!ctl_r.multiproc_filter_enable || rx_sh_r[8]) begin
                rx_buf_nxt  = rx_sh_r[7:0];
                rx_ninth    = rx_sh_r[8];
                rx_load_evt = 1'b1;
              end
            end
          end else begin
            rx_ph_nxt = rx_ph_r + 4'd1;
          end
        end
      end
      default: rx_state_nxt = USP_RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rx_state_r <= USP_RX_IDLE;
      rx_ph_r    <= 4'd0;
      rx_cnt_r   <= 4'd0;
      rx_sh_r    <= 9'h000;
      rx_buf_r   <= 8'h00;
      rxd_prev_r <= 1'b1;
    end else if (ce_in) begin
      rx_state_r <= rx_state_nxt;
      rx_ph_r    <= rx_ph_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      rx_sh_r    <= rx_sh_nxt;
      rx_buf_r   <= rx_buf_nxt;
      rxd_prev_r <= rxd_in;
    end
  end

  // Pins
  always_comb begin
    txd_nxt      = 1'b1;
    rxd_o_nxt    = tx_shift_r[0];
    rxd_oe_n_nxt = 1'b1;
    if (is_m0) begin
      if (tx_state_r == USP_TX_SHIFT) begin
        txd_nxt      = (tx_ph_r >= `USP_M0_HIGH);
        rxd_oe_n_nxt = 1'b0;
      end else if (rx_state_r == USP_RX_DATA) begin
        txd_nxt = (rx_ph_r >= `USP_M0_HIGH);
      end
    end else if (tx_state_r == USP_TX_SHIFT) begin
      txd_nxt = tx_shift_r[0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      txd_r      <= 1'b1;
      rxd_o_r    <= 1'b1;
      rxd_oe_n_r <= 1'b1;
    end else if (ce_in) begin
      txd_r      <= txd_nxt;
      rxd_o_r    <= rxd_o_nxt;
      rxd_oe_n_r <= rxd_oe_n_nxt;
    end
  end

  assign sfr_rdata_out        = rdata_r;
  assign txd_out              = txd_r;
  assign rxd_out              = rxd_o_r;
  assign rxd_oe_n_out         = rxd_oe_n_r;
  assign tx_done_flag_out     = ctl_r.tx_done_flag;
  assign rx_done_flag_out     = ctl_r.rx_done_flag;
  assign frame_error_flag_out = ferr_r;
endmodule : usp_serial_port

// ### usp_serial_port_chk.sv
// Purpose: Port assertions for the serial port
// Assumes: Bench keeps ce_in high except for one write in t_regs, and pulses timer overflow every second clock
// Notes:   Frame windows assume bit times of at most 32 clocks
`timescale 1ns/1ps
module usp_serial_port_chk
  import usp_pkg::*;
(
  input wire logic         ref_clk_in,
  input wire logic         sys_rst_in,
  input wire logic         ce_in,
  input wire usp_sfr_req_t sfr_req_in,
  input wire logic [7:0]   sfr_rdata_out,
  input wire logic         bit7_view_select_in,
  input wire logic         fixed_rate_select_in,
  input wire logic         t1_overflow_in,
  input wire logic         rxd_in,
  input wire logic         rxd_out,
  input wire logic         rxd_oe_n_out,
  input wire logic         txd_out,
  input wire logic         tx_done_flag_out,
  input wire logic         rx_done_flag_out,
  input wire logic         frame_error_flag_out
);
  logic       buf_wr;
  logic       ctl_wr;
  logic       bad_rd;
  logic [9:0] since_wr_r;
  logic [9:0] since_wr_nxt;
  assign buf_wr = ce_in && sfr_req_in.wr && sfr_req_in.addr == 8'h99;
  assign ctl_wr = ce_in && (sfr_req_in.wr || sfr_req_in.bit_wr) && sfr_req_in.addr == 8'h98;
  assign bad_rd = ce_in && sfr_req_in.rd && sfr_req_in.addr != 8'h98 && sfr_req_in.addr != 8'h99;
  // Parked at the top after reset so a flag with no cause shows up
  always_comb begin
    since_wr_nxt = since_wr_r;
    if (buf_wr) begin
      since_wr_nxt = 10'h000;
    end else if (since_wr_r != 10'h3ff) begin
      since_wr_nxt = since_wr_r + 10'h001;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      since_wr_r <= 10'h3ff;
    end else begin
      since_wr_r <= since_wr_nxt;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_m0_low;
    !txd_out [*2];
  endsequence
  sequence s_m0_high;
    txd_out [*3];
  endsequence
  property p_reset;
    disable iff (1'b0) sys_rst_in |=> txd_out && rxd_oe_n_out && sfr_rdata_out == 8'h00
      && !tx_done_flag_out && !rx_done_flag_out && !frame_error_flag_out;
  endproperty
  property p_rd_idle;
    ce_in && !sfr_req_in.rd |=> sfr_rdata_out == 8'h00;
  endproperty
  property p_rd_unmapped;
    bad_rd |=> sfr_rdata_out == 8'h00;
  endproperty
  property p_tx_start;
    buf_wr |-> ##[1:40] !txd_out;
  endproperty
  property p_tx_done;
    $rose(tx_done_flag_out) |-> since_wr_r >= 10'h028 && since_wr_r <= 10'h190;
  endproperty
  property p_oe_window;
    !rxd_oe_n_out |-> since_wr_r <= 10'h040;
  endproperty
  property p_ferr_sticky;
    frame_error_flag_out && !ctl_wr |=> frame_error_flag_out;
  endproperty
  property p_rxdone_sticky;
    rx_done_flag_out && !ctl_wr |=> rx_done_flag_out;
  endproperty
  property p_txdone_sticky;
    tx_done_flag_out && !ctl_wr |=> tx_done_flag_out;
  endproperty
  property p_m0_clock;
    $fell(txd_out) && !rxd_oe_n_out |=> s_m0_low ##1 s_m0_high;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
  a_tx_start: assert property (p_tx_start) else $error("no transmit start");
  a_tx_done: assert property (p_tx_done) else $error("transmit done mistimed");
  a_oe_window: assert property (p_oe_window) else $error("pin driven too long");
  a_ferr_sticky: assert property (p_ferr_sticky) else $error("framing flag lost");
  a_rxdone_sticky: assert property (p_rxdone_sticky) else $error("receive flag lost");
  a_txdone_sticky: assert property (p_txdone_sticky) else $error("transmit flag lost");
  a_m0_clock: assert property (p_m0_clock) else $error("shift clock shape");
endmodule : usp_serial_port_chk

// ### usp_remote_model.sv
// Purpose: Remote transceiver and shift-register partner on the serial lines
// Assumes: Tasks are entered just after a clock edge
// Notes:   Line idles high because the model drives drv_out to 1 whenever it is not sending
`timescale 1ns/1ps
module usp_remote_model (
  input  wire logic clk_in,
  input  wire logic txd_in,
  input  wire logic line_in,
  output logic      drv_out,
  output logic      tmo_out
);
  initial begin
    drv_out = 1'b1;
    tmo_out = 1'b0;
  end
  task automatic wait_lvl(input logic lvl);
    int k;
    k = 0;
    while (txd_in !== lvl && k < 4000) begin
      @(posedge clk_in);
      k++;
    end
    if (k == 4000) begin
      tmo_out = 1'b1;
    end
  endtask : wait_lvl
  // Index 0 goes first; one idle bit time follows so frames never merge
  task automatic send(input logic [10:0] bits, input int n, input int bc);
    for (int i = 0; i <= n; i++) begin
      drv_out = (i == n) ? 1'b1 : bits[i];
      repeat (bc) @(posedge clk_in);
      #1;
    end
  endtask : send
  task automatic grab(input int n, input int bc, output logic [10:0] bits);
    bits = 11'h000;
    wait_lvl(1'b0);
    repeat (bc / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_in;
      repeat (bc) @(posedge clk_in);
    end
  endtask : grab
  // Samples on the clock rise, presents the next bit once it has risen
  task automatic shift0(input logic [7:0] out_b, output logic [7:0] in_b);
    in_b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      drv_out = out_b[i];
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      in_b[i] = line_in;
      #1;
    end
    drv_out = 1'b1;
    repeat (6) @(posedge clk_in);
  endtask : shift0
endmodule : usp_remote_model

// ### uart_serial_port_tb_top.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Remote model on the serial lines, register strobes from tasks
// Notes:   Timer overflow pulses every second clock, so a timed bit is 32 clocks
`timescale 1ns/1ps
module uart_serial_port_tb_top;
  import usp_pkg::*;
  logic         ref_clk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic         ce_in      = 1'b1;
  usp_sfr_req_t req        = '0;
  logic         view_sel   = 1'b0;
  logic         fast_sel   = 1'b1;
  logic         t1_ovf     = 1'b0;
  logic [7:0]   rdata;
  logic [7:0]   got;
  logic [7:0]   m0_in;
  logic [10:0]  fr;
  logic         rxd_out, rxd_oe_n, txd, tx_done, rx_done, ferr, mdl_drv, mdl_tmo;
  wire          rxd_line = rxd_oe_n ? mdl_drv : rxd_out;
  int           errors    = 0;
  int           cmp_count = 0;
  usp_serial_port dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .sfr_req_in(req), .sfr_rdata_out(rdata), .bit7_view_select_in(view_sel),
    .fixed_rate_select_in(fast_sel), .t1_overflow_in(t1_ovf), .rxd_in(rxd_line),
    .rxd_out(rxd_out), .rxd_oe_n_out(rxd_oe_n), .txd_out(txd), .tx_done_flag_out(tx_done),
    .rx_done_flag_out(rx_done), .frame_error_flag_out(ferr));
  usp_remote_model mdl (.clk_in(ref_clk_in), .txd_in(txd), .line_in(rxd_line),
    .drv_out(mdl_drv), .tmo_out(mdl_tmo));
  always #25 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) #1 t1_ovf = ~t1_ovf;
  always @(posedge mdl_tmo) begin
    errors++;
    finish_test();
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      errors++;
    end
  endtask : chk
  // Op 0 read, 1 byte write, 2 bit write with index d[2:0] and value d[7]
  task automatic sfr(input logic [7:0] a, input logic [1:0] op, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    req.addr    = a;
    req.rd      = (op == 2'h0);
    req.wr      = (op == 2'h1);
    req.bit_wr  = (op == 2'h2);
    req.wdata   = d;
    req.bit_sel = d[2:0];
    req.bit_val = d[7];
    @(posedge ref_clk_in);
    #1;
    got = rdata;
    req = '0;
  endtask : sfr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    sfr(a, 2'h0, 8'h00);
    chk({3'h0, got}, {3'h0, e});
  endtask : rdchk
  task automatic t_regs();
    rdchk(8'h98, 8'h00);
    rdchk(8'h99, 8'h00);
    sfr(8'h97, 2'h1, 8'h5a);
    rdchk(8'h97, 8'h00);
    // Clock enable low must swallow the write
    ce_in = 1'b0;
    sfr(8'h98, 2'h1, 8'h10);
    ce_in = 1'b1;
    rdchk(8'h98, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_m1_tx();
    sfr(8'h98, 2'h1, 8'h40);
    fork
      sfr(8'h99, 2'h1, 8'ha5);
      mdl.grab(10, 32, fr);
    join
    chk(fr, {1'b0, 1'b1, 8'ha5, 1'b0});
    chk({10'h000, tx_done}, 11'h001);
    rdchk(8'h98, 8'h42);
    sfr(8'h98, 2'h1, 8'h40);
    mdl.send({1'b0, 1'b1, 8'h77, 1'b0}, 10, 32);
    rdchk(8'h98, 8'h40);
    $display("test m1_tx done");
  endtask : t_m1_tx
  task automatic t_m2_duplex();
    fast_sel = 1'b1;
    sfr(8'h98, 2'h1, 8'h98);
    fork
      sfr(8'h99, 2'h1, 8'h3c);
      mdl.grab(11, 16, fr);
      mdl.send({1'b1, 1'b0, 8'h5a, 1'b0}, 11, 16);
    join
    chk(fr, {1'b1, 1'b1, 8'h3c, 1'b0});
    chk({10'h000, rx_done}, 11'h001);
    rdchk(8'h98, 8'h9b);
    rdchk(8'h99, 8'h5a);
    $display("test m2_duplex done");
  endtask : t_m2_duplex
  task automatic t_m2_fe();
    fast_sel = 1'b0;
    sfr(8'h98, 2'h1, 8'h90);
    mdl.send({1'b0, 1'b0, 8'h11, 1'b0}, 11, 32);
    mdl.send({1'b1, 1'b0, 8'h22, 1'b0}, 11, 32);
    rdchk(8'h99, 8'h22);
    view_sel = 1'b1;
    rdchk(8'h98, 8'h91);
    sfr(8'h98, 2'h2, 8'h07);
    rdchk(8'h98, 8'h11);
    view_sel = 1'b0;
    rdchk(8'h98, 8'h91);
    $display("test m2_fe done");
  endtask : t_m2_fe
  task automatic t_m1_filter();
    sfr(8'h98, 2'h1, 8'h70);
    mdl.send({1'b0, 1'b0, 8'h33, 1'b0}, 10, 32);
    rdchk(8'h98, 8'h70);
    chk({10'h000, ferr}, 11'h001);
    mdl.send({1'b0, 1'b1, 8'h44, 1'b0}, 10, 32);
    rdchk(8'h98, 8'h75);
    rdchk(8'h99, 8'h44);
    $display("test m1_filter done");
  endtask : t_m1_filter
  task automatic t_m3_filter();
    sfr(8'h98, 2'h1, 8'hf0);
    mdl.send({1'b1, 1'b0, 8'h55, 1'b0}, 11, 32);
    rdchk(8'h98, 8'hf0);
    mdl.send({1'b1, 1'b1, 8'h66, 1'b0}, 11, 32);
    rdchk(8'h98, 8'hf5);
    rdchk(8'h99, 8'h66);
    chk({10'h000, ferr}, 11'h001);
    $display("test m3_filter done");
  endtask : t_m3_filter
  task automatic t_m0();
    sfr(8'h98, 2'h1, 8'h00);
    fork
      sfr(8'h99, 2'h1, 8'hc3);
      mdl.shift0(8'h00, m0_in);
    join
    chk({3'h0, m0_in}, 11'h0c3);
    rdchk(8'h98, 8'h02);
    fork
      sfr(8'h98, 2'h1, 8'h10);
      mdl.shift0(8'hb6, m0_in);
    join
    rdchk(8'h98, 8'h11);
    rdchk(8'h99, 8'hb6);
    $display("test m0 done");
  endtask : t_m0
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_regs();
    t_m1_tx();
    t_m2_duplex();
    t_m2_fe();
    t_m1_filter();
    t_m3_filter();
    t_m0();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    errors++;
    finish_test();
  end
endmodule : uart_serial_port_tb_top
bind usp_serial_port usp_serial_port_chk u_chk (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .ce_in(ce_in), .sfr_req_in(sfr_req_in),
  .sfr_rdata_out(sfr_rdata_out), .bit7_view_select_in(bit7_view_select_in),
  .fixed_rate_select_in(fixed_rate_select_in), .t1_overflow_in(t1_overflow_in),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n_out(rxd_oe_n_out), .txd_out(txd_out),
  .tx_done_flag_out(tx_done_flag_out), .rx_done_flag_out(rx_done_flag_out),
  .frame_error_flag_out(frame_error_flag_out));
